// File: logic/iem_pkg.sv
// constants shared by the interrupt-enable bank and its flag store
package iem_pkg;

   // bus geometry
   localparam int unsigned ADDR_W = 12;
   localparam int unsigned DATA_W = 32;

   // byte offsets of the registers
   localparam logic [11:0] OFS_FLAG   = 12'h008;
   localparam logic [11:0] OFS_ENABLE = 12'h00c;
   localparam logic [11:0] OFS_CLEAR  = 12'h040;

   // field positions, shared by the flag and the enable layout
   localparam int unsigned BIT_WR_ADDR_MATCH = 23;
   localparam int unsigned BIT_RD_ADDR_MATCH = 22;
   localparam int unsigned BIT_MODE_MATCH    = 16;
   localparam int unsigned BIT_TX_LOCKOUT    = 15;
   localparam int unsigned BIT_STOP_ERR      = 14;
   localparam int unsigned BIT_START_ERR     = 13;
   localparam int unsigned BIT_DNR_ERR       = 12;
   localparam int unsigned BIT_DATA_NACK     = 11;
   localparam int unsigned BIT_ADDR_NACK     = 10;
   localparam int unsigned BIT_TIMEOUT       = 9;
   localparam int unsigned BIT_ARB_LOST      = 8;

   // implemented positions; everything else is reserved and reads zero
   localparam logic [31:0] IMPL_MASK = 32'h00c1_ff00;

   // values after reset
   localparam logic [31:0] RST_ENABLE = 32'h0000_0000;
   localparam logic [31:0] RST_FLAG   = 32'h0000_0000;
   localparam logic [31:0] RST_RDATA  = 32'h0000_0000;

endpackage

// File: logic/iem_flag_bank.sv
// sticky event flags, cleared by writing one, set winning over clear
`timescale 1ns/10ps
module iem_flag_bank #(
   parameter int unsigned WIDTH = 32
) (
   input  wire logic             pclk,
   input  wire logic             presetn,
   input  wire logic [WIDTH-1:0] set_i,
   input  wire logic [WIDTH-1:0] clr_i,
   input  wire logic [WIDTH-1:0] keep_mask_i,
   output logic      [WIDTH-1:0] flag_o
);

   logic [WIDTH-1:0] flag_nxt;   // next flag value

   // an event landing with its own clear is kept, so no event is lost
   always_comb begin
      flag_nxt = ((flag_o & ~clr_i) | set_i) & keep_mask_i;
   end

   // flag storage
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flag_o <= iem_pkg::RST_FLAG[WIDTH-1:0];
      end else begin
         flag_o <= flag_nxt;
      end
   end

endmodule

// File: logic/iem_top.sv
// interrupt enable bank (upper half) with flag store and apb slave
//
// Behaviour
// (R1) bit 23 gates target write address match
// (R2) bit 22 gates target read address match
// (R3) bit 14 gates out-of-sequence stop
// (R4) bit 13 gates out-of-sequence start
// (R5) bit 12 gates target do-not-respond
// (R6) bit 11 gates controller data nack
// (R7) bit 10 gates controller address nack
// (R8) bit 9 gates bus timeout error
// (R9) bit 8 gates arbitration lost
// (R10) bit 15 gates transmit fifo lockout
// (R11) flags clear on write one, zero ignored
// (R12) irq when flag and enable; reserved zero
//
// Implementation choice: the APB register port.
`timescale 1ns/10ps
module iem_top (
   input  wire logic        pclk,
   input  wire logic        presetn,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   input  wire logic [3:0]  pstrb,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // event pulses from the protocol engine, same clock
   input  wire logic        evt_wr_addr_match,
   input  wire logic        evt_rd_addr_match,
   input  wire logic        evt_mode_match,
   input  wire logic        evt_tx_lockout,
   input  wire logic        evt_stop_err,
   input  wire logic        evt_start_err,
   input  wire logic        evt_dnr_err,
   input  wire logic        evt_data_nack,
   input  wire logic        evt_addr_nack,
   input  wire logic        evt_timeout,
   input  wire logic        evt_arb_lost,
   // interrupt request
   output logic             irq,
   // enable field view for the engine
   output logic             timeout_fault_enable
);

   // register map, one aligned word each, 12-bit byte address
   //   flag word    read, write one to clear a flag, writing zero keeps it
   //   enable word  read/write irq_enable_first, reserved bits stay zero
   //   clear word   write-only alias of the flag clear, reads zero
   //   anything else answers with an error, reads zero and drops the write
   // layout shared by flags and enables (bit: event)
   //   23 write address match, 22 read address match, 16 mode match
   //   15 transmit lockout, 14 stop error, 13 start error, 12 do-not-respond
   //   11 data nack, 10 address nack, 9 timeout, 8 arbitration lost
   // the bus answers with zero wait states; pready is a flop raised in setup

   // register selector
   typedef enum logic [1:0] {
      IEM_SEL_NONE,
      IEM_SEL_FLAG,
      IEM_SEL_ENABLE,
      IEM_SEL_CLEAR
   } iem_sel_e;

   logic [31:0] evt_vec;        // events in register layout
   logic [31:0] flag_r;         // sticky flags
   logic [31:0] flag_clr;       // clear request to the flag store
   logic [31:0] en_r;           // irq_enable_first
   logic [31:0] en_nxt;         // next enable value
   logic [31:0] wmask;          // byte lanes as a bit mask
   logic        setup_ph;       // apb setup cycle
   logic        access_done;    // apb access completing this edge
   logic        wr_done;        // write taking effect this edge
   iem_sel_e    acc_sel;        // register under the current address
   logic [31:0] rdata_nxt;      // read value captured at setup
   logic        irq_nxt;        // next interrupt level

   // address decode, used by the read path and the write path
   function automatic iem_sel_e decode(input logic [11:0] addr);
      iem_sel_e s;
      s = IEM_SEL_NONE;
      if (addr[11:2] == iem_pkg::OFS_FLAG[11:2]) begin
         // flag word; byte offset bits are ignored
         s = IEM_SEL_FLAG;
      end else if (addr[11:2] == iem_pkg::OFS_ENABLE[11:2]) begin
         // irq_enable_first
         s = IEM_SEL_ENABLE;
      end else if (addr[11:2] == iem_pkg::OFS_CLEAR[11:2]) begin
         // write-only clear alias
         s = IEM_SEL_CLEAR;
      end
      return s;
   endfunction

   // gather the event pulses into the shared layout
   always_comb begin
      evt_vec = 32'h0000_0000;
      evt_vec[iem_pkg::BIT_WR_ADDR_MATCH] = evt_wr_addr_match;   // R1
      evt_vec[iem_pkg::BIT_RD_ADDR_MATCH] = evt_rd_addr_match;   // R2
      evt_vec[iem_pkg::BIT_MODE_MATCH]    = evt_mode_match;
      evt_vec[iem_pkg::BIT_TX_LOCKOUT]    = evt_tx_lockout;      // R10
      evt_vec[iem_pkg::BIT_STOP_ERR]      = evt_stop_err;        // R3
      evt_vec[iem_pkg::BIT_START_ERR]     = evt_start_err;       // R4
      evt_vec[iem_pkg::BIT_DNR_ERR]       = evt_dnr_err;         // R5
      evt_vec[iem_pkg::BIT_DATA_NACK]     = evt_data_nack;       // R6
      evt_vec[iem_pkg::BIT_ADDR_NACK]     = evt_addr_nack;       // R7
      evt_vec[iem_pkg::BIT_TIMEOUT]       = evt_timeout;         // R8
      evt_vec[iem_pkg::BIT_ARB_LOST]      = evt_arb_lost;        // R9
   end

   // bus phase decode; pready is a flop, so the access ends one cycle after setup
   always_comb begin
      setup_ph    = psel & ~penable;
      access_done = psel & penable & pready;
      wr_done     = access_done & pwrite;
      acc_sel     = decode(paddr);
      wmask       = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
   end

   // clear requests: flag register and clear register both take write-one
   always_comb begin
      flag_clr = 32'h0000_0000;
      if (wr_done && (acc_sel == IEM_SEL_FLAG || acc_sel == IEM_SEL_CLEAR)) begin
         flag_clr = pwdata & wmask & iem_pkg::IMPL_MASK;   // R11
      end
   end

   // flag store; reserved positions never hold a one
   iem_flag_bank #(
      .WIDTH (32)
   ) u_flags (
      .pclk        (pclk),
      .presetn     (presetn),
      .set_i       (evt_vec),
      .clr_i       (flag_clr),
      .keep_mask_i (iem_pkg::IMPL_MASK),
      .flag_o      (flag_r)
   );

   // enable register write; reserved bits ignore writes
   always_comb begin
      en_nxt = en_r;
      if (wr_done && acc_sel == IEM_SEL_ENABLE) begin
         en_nxt = ((en_r & ~wmask) | (pwdata & wmask)) & iem_pkg::IMPL_MASK;   // R12
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         en_r <= iem_pkg::RST_ENABLE;
      end else begin
         en_r <= en_nxt;
      end
   end

   // read mux; the clear register is write-only and reads zero
   always_comb begin
      unique case (acc_sel)
         // live flags; an event after setup shows on the next read
         IEM_SEL_FLAG: begin
            rdata_nxt = flag_r & iem_pkg::IMPL_MASK;
         end
         // enable register, reserved bits forced low
         IEM_SEL_ENABLE: begin
            rdata_nxt = en_r & iem_pkg::IMPL_MASK;   // R12
         end
         // write-only word reads zero
         IEM_SEL_CLEAR: begin
            rdata_nxt = 32'h0000_0000;
         end
         // unmapped: zero data, the error is raised separately
         IEM_SEL_NONE: begin
            rdata_nxt = 32'h0000_0000;
         end
      endcase
   end

   // apb answer: data and error captured in setup, held through access
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata  <= iem_pkg::RST_RDATA;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else if (setup_ph) begin
         // setup: raise pready for the access cycle, a write answers zero data
         prdata  <= pwrite ? 32'h0000_0000 : rdata_nxt;
         pready  <= 1'b1;
         pslverr <= (acc_sel == IEM_SEL_NONE);
      end else begin
         // limitation: read data are a snapshot of the setup cycle
         prdata  <= 32'h0000_0000;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end
   end

   // interrupt level: any flag with its enable set
   always_comb begin
      irq_nxt = |(flag_r & en_r & iem_pkg::IMPL_MASK);   // R12
   end

   // outputs from flops; irq one cycle behind the flags, glitch free
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq                  <= 1'b0;
         timeout_fault_enable <= 1'b0;
      end else begin
         irq                  <= irq_nxt;
         timeout_fault_enable <= en_nxt[iem_pkg::BIT_TIMEOUT];   // R8
      end
   end

   // assertions, kept beside the logic that they watch
   // the helpers below only restate bus and event facts, so a check never
   // reuses the expression that it is meant to judge
   logic [31:0] clr_seen;    // write-one bits of the write completing this edge
   logic        clr_valid;   // this edge carries a flag clear with no event
   always_comb begin
      clr_seen  = flag_clr;
      clr_valid = wr_done && (|flag_clr) && !(|evt_vec);
   end

   // an enabled event shows on irq two edges later
   property p_evt_irq(logic e, logic en);
      @(posedge pclk) disable iff (!presetn)
         (e && en && !wr_done) ##1 en |=> irq;
   endproperty

   a_wr_match_irq: assert property (p_evt_irq(evt_wr_addr_match, // R1
      en_r[iem_pkg::BIT_WR_ADDR_MATCH])) else $error("write match irq missing");
   a_rd_match_irq: assert property (p_evt_irq(evt_rd_addr_match, // R2
      en_r[iem_pkg::BIT_RD_ADDR_MATCH])) else $error("read match irq missing");
   a_stop_err_irq: assert property (p_evt_irq(evt_stop_err, // R3
      en_r[iem_pkg::BIT_STOP_ERR])) else $error("stop error irq missing");
   a_start_err_irq: assert property (p_evt_irq(evt_start_err, // R4
      en_r[iem_pkg::BIT_START_ERR])) else $error("start error irq missing");
   a_dnr_err_irq: assert property (p_evt_irq(evt_dnr_err, // R5
      en_r[iem_pkg::BIT_DNR_ERR])) else $error("dnr irq missing");
   a_data_nack_irq: assert property (p_evt_irq(evt_data_nack, // R6
      en_r[iem_pkg::BIT_DATA_NACK])) else $error("data nack irq missing");
   a_addr_nack_irq: assert property (p_evt_irq(evt_addr_nack, // R7
      en_r[iem_pkg::BIT_ADDR_NACK])) else $error("address nack irq missing");
   a_timeout_irq: assert property (p_evt_irq(evt_timeout, // R8
      en_r[iem_pkg::BIT_TIMEOUT])) else $error("timeout irq missing");
   a_arb_lost_irq: assert property (p_evt_irq(evt_arb_lost, // R9
      en_r[iem_pkg::BIT_ARB_LOST])) else $error("arbitration irq missing");
   a_lockout_irq: assert property (p_evt_irq(evt_tx_lockout, // R10
      en_r[iem_pkg::BIT_TX_LOCKOUT])) else $error("lockout irq missing");

   // masked flags never raise irq
   a_masked_quiet: assert property (@(posedge pclk) disable iff (!presetn) // R12
      !(|(flag_r & en_r)) |=> !irq) else $error("irq without enabled flag");

   // write one clears, write zero keeps
   a_w1c_clear: assert property (@(posedge pclk) disable iff (!presetn) // R11
      clr_valid |=> ((flag_r & $past(clr_seen)) == 32'h0000_0000)
                 && ((flag_r & ~$past(clr_seen)) == ($past(flag_r) & ~$past(clr_seen))))
      else $error("write-one clear misbehaved");

   // a timeout set wins over a timeout clear in the same cycle
   a_set_wins: assert property (@(posedge pclk) disable iff (!presetn) // R11
      (evt_timeout && flag_clr[iem_pkg::BIT_TIMEOUT]) |=> flag_r[iem_pkg::BIT_TIMEOUT])
      else $error("event lost under clear");

   // reserved positions read zero
   a_reserved_zero: assert property (@(posedge pclk) disable iff (!presetn) // R12
      (access_done && !pwrite) |-> ((prdata & ~iem_pkg::IMPL_MASK) == 32'h0000_0000))
      else $error("reserved bits read nonzero");

   // the access ends one cycle after setup
   a_zero_wait: assert property (@(posedge pclk) disable iff (!presetn)
      setup_ph |=> pready) else $error("pready late");

   // pready stands for exactly one cycle
   a_ready_pulse: assert property (@(posedge pclk) disable iff (!presetn)
      pready
      |=> !pready)
      else $error("pready held too long");

   // read data are zero outside the access cycle
   a_rdata_idle: assert property (@(posedge pclk) disable iff (!presetn)
      !pready
      |-> (prdata == 32'h0000_0000))
      else $error("prdata not zero while idle");

   // an error is only reported together with pready
   a_slverr_ready: assert property (@(posedge pclk) disable iff (!presetn)
      pslverr
      |-> pready)
      else $error("pslverr without pready");

   // an unmapped address answers with an error
   a_unmapped_err: assert property (@(posedge pclk) disable iff (!presetn)
      (setup_ph && acc_sel == IEM_SEL_NONE)
      |=> (pready && pslverr))
      else $error("unmapped access without error");

   // the write-only clear word reads zero
   a_clear_reads_zero: assert property (@(posedge pclk) disable iff (!presetn)
      (setup_ph && !pwrite && acc_sel == IEM_SEL_CLEAR)
      |=> (prdata == 32'h0000_0000))
      else $error("clear word read nonzero");

   // reserved enable positions never hold a one
   a_enable_reserved: assert property (@(posedge pclk) disable iff (!presetn) // R12
      (en_r & ~iem_pkg::IMPL_MASK) == 32'h0000_0000)
      else $error("reserved enable bit set");

   // reserved flag positions never hold a one
   a_flag_reserved: assert property (@(posedge pclk) disable iff (!presetn) // R12
      (flag_r & ~iem_pkg::IMPL_MASK) == 32'h0000_0000)
      else $error("reserved flag bit set");

   // a full-word enable write lands at its access edge
   a_enable_write: assert property (@(posedge pclk) disable iff (!presetn) // R12
      (wr_done && acc_sel == IEM_SEL_ENABLE && pstrb == 4'hf)
      |=> (en_r == ($past(pwdata) & iem_pkg::IMPL_MASK)))
      else $error("enable write lost");

   // every event leaves its flag set one edge later
   a_event_flag: assert property (@(posedge pclk) disable iff (!presetn) // R11
      (|evt_vec)
      |=> ((flag_r & $past(evt_vec)) == $past(evt_vec)))
      else $error("event did not set its flag");

   // a flag rises only on an event
   a_flag_needs_event: assert property (@(posedge pclk) disable iff (!presetn) // R11
      1'b1
      |=> ((flag_r & ~$past(flag_r) & ~$past(evt_vec)) == 32'h0000_0000))
      else $error("flag rose without event");

   // the engine's copy of enable bit 9 tracks the register
   a_timeout_view: assert property (@(posedge pclk) disable iff (!presetn) // R8
      timeout_fault_enable == en_r[iem_pkg::BIT_TIMEOUT])
      else $error("timeout enable view differs");

   // main scenarios worth seeing in a run
   cover_enabled_irq: cover property (@(posedge pclk) disable iff (!presetn)
      $rose(irq));
   cover_clear_irq: cover property (@(posedge pclk) disable iff (!presetn)
      irq ##1 clr_valid ##2 !irq);
   cover_unmapped: cover property (@(posedge pclk) disable iff (!presetn)
      access_done && pslverr);
   cover_set_clear: cover property (@(posedge pclk) disable iff (!presetn)
      |(evt_vec & flag_clr));
   cover_masked_event: cover property (@(posedge pclk) disable iff (!presetn)
      (|(flag_r & ~en_r & iem_pkg::IMPL_MASK)) && !irq);

endmodule

// File: tb/tb_top.sv
// self-checking bench for the interrupt enable bank: apb access, events, irq
`timescale 1ns/10ps
module tb_top;
   logic        pclk    = 1'b0;   // 40 MHz bus clock
   logic        presetn = 1'b0;   // held low for four cycles
   logic        psel    = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite  = 1'b0;
   logic [11:0] paddr   = 12'h000;
   logic [31:0] pwdata  = 32'h0000_0000;
   logic [3:0]  pstrb   = 4'hf;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic [10:0] evt     = 11'h000; // one line per event, order of pos[] below
   logic        irq;
   logic        timeout_fault_enable;
   logic [31:0] rd;                // last read data
   logic        se;                // last slave error
   logic [31:0] bit_m;             // mask of the event under test
   int          err_count = 0;
   int          n_tests   = 0;
   int unsigned pos [11] = '{iem_pkg::BIT_WR_ADDR_MATCH, iem_pkg::BIT_RD_ADDR_MATCH,
      iem_pkg::BIT_MODE_MATCH, iem_pkg::BIT_TX_LOCKOUT, iem_pkg::BIT_STOP_ERR,
      iem_pkg::BIT_START_ERR, iem_pkg::BIT_DNR_ERR, iem_pkg::BIT_DATA_NACK,
      iem_pkg::BIT_ADDR_NACK, iem_pkg::BIT_TIMEOUT, iem_pkg::BIT_ARB_LOST};

   // free-running clock, 25 ns period
   always #12.5 pclk = ~pclk;

   iem_top u_iem_top (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .evt_wr_addr_match(evt[0]), .evt_rd_addr_match(evt[1]),
      .evt_mode_match(evt[2]), .evt_tx_lockout(evt[3]), .evt_stop_err(evt[4]),
      .evt_start_err(evt[5]), .evt_dnr_err(evt[6]), .evt_data_nack(evt[7]),
      .evt_addr_nack(evt[8]), .evt_timeout(evt[9]), .evt_arb_lost(evt[10]),
      .irq(irq), .timeout_fault_enable(timeout_fault_enable));

   // prints the counts and the verdict, then stops
   task automatic complete_run();
      $display("checks %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   // one comparison, four-state exact
   task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
      n_tests++;
      if (got !== exp) begin
         err_count++;
         $display("MISMATCH t=%0t %s got %h exp %h", $time, msg, got, exp);
      end
   endtask

   // one apb transfer; request held until pready is sampled high
   task automatic apb_xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
                           input logic [3:0] s);
      int n;
      @(posedge pclk);
      psel    <= 1'b1;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      pstrb   <= s;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      // answer taken at the very edge that saw pready
      rd      = prdata;
      se      = pslverr;
      if (pready !== 1'b1) check(32'h0, 32'h1, "pready never came");
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic apb_wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
      apb_xfer(1'b1, a, d, s);
   endtask

   task automatic apb_rd(input logic [11:0] a);
      apb_xfer(1'b0, a, 32'h0000_0000, 4'hf);
   endtask

   // single-cycle event pulse, then time for flag and irq to settle
   task automatic pulse(input int i);
      @(posedge pclk);
      evt[i] <= 1'b1;
      @(posedge pclk);
      evt[i] <= 1'b0;
      repeat (3) @(posedge pclk);
      #1;
   endtask

   // one-hot mask of the event at index i
   function automatic logic [31:0] pos_mask(input int i);
      return 32'h1 << pos[i];
   endfunction

   // main sequence
   initial begin
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      apb_rd(iem_pkg::OFS_ENABLE);
      check(rd, iem_pkg::RST_ENABLE, "enable after reset");
      check({31'h0, se}, 32'h0, "mapped read no error");
      apb_rd(iem_pkg::OFS_FLAG);
      check(rd, iem_pkg::RST_FLAG, "flags after reset");
      // reserved positions must drop the ones written there
      apb_wr(iem_pkg::OFS_ENABLE, 32'hffff_ffff, 4'hf);
      apb_rd(iem_pkg::OFS_ENABLE);
      check(rd, iem_pkg::IMPL_MASK, "enable readback");
      check({31'h0, timeout_fault_enable}, 32'h1, "timeout enable view");
      // lane 1 only: bits 15:8 cleared, upper lanes kept
      apb_wr(iem_pkg::OFS_ENABLE, 32'h0000_0000, 4'b0010);
      apb_rd(iem_pkg::OFS_ENABLE);
      check(rd, 32'h00c1_0000, "lane strobe write");
      check({31'h0, timeout_fault_enable}, 32'h0, "timeout enable off");
      $display("test registers done");
      // every event: enabled raises irq, zero write keeps, one write clears, masked stays low
      for (int i = 0; i < 11; i++) begin
         bit_m = 32'h1 << pos[i];
         apb_wr(iem_pkg::OFS_ENABLE, bit_m, 4'hf);
         pulse(i);
         check({31'h0, irq}, 32'h1, "irq enabled event");
         apb_wr(iem_pkg::OFS_FLAG, 32'h0000_0000, 4'hf);
         apb_rd(iem_pkg::OFS_FLAG);
         check(rd, bit_m, "flag kept on zero write");
         apb_wr(iem_pkg::OFS_FLAG, bit_m, 4'hf);
         repeat (2) @(posedge pclk);
         #1;
         check({31'h0, irq}, 32'h0, "irq after clear");
         apb_wr(iem_pkg::OFS_ENABLE, ~bit_m, 4'hf);
         pulse(i);
         check({31'h0, irq}, 32'h0, "irq masked event");
         apb_rd(iem_pkg::OFS_FLAG);
         check(rd, bit_m, "masked flag still set");
         apb_wr(iem_pkg::OFS_CLEAR, bit_m, 4'hf);
         apb_rd(iem_pkg::OFS_FLAG);
         check(rd, 32'h0000_0000, "flag after clear alias");
      end
      // an event on the very edge of its own clear keeps the flag
      pulse(9);
      fork
         apb_wr(iem_pkg::OFS_FLAG, 32'h1 << iem_pkg::BIT_TIMEOUT, 4'hf);
         begin
            repeat (2) @(posedge pclk);
            evt[9] <= 1'b1;
            @(posedge pclk);
            evt[9] <= 1'b0;
         end
      join
      apb_rd(iem_pkg::OFS_FLAG);
      check(rd, 32'h1 << iem_pkg::BIT_TIMEOUT, "set wins over clear");
      apb_rd(iem_pkg::OFS_CLEAR);
      check(rd, 32'h0000_0000, "clear word reads zero");
      check({31'h0, se}, 32'h0, "clear word no error");
      apb_wr(iem_pkg::OFS_CLEAR, 32'h1 << iem_pkg::BIT_TIMEOUT, 4'hf);
      apb_rd(iem_pkg::OFS_FLAG);
      check(rd, 32'h0000_0000, "flag after late clear");
      $display("test events done");
      // unmapped place: error, zero data, write ignored
      apb_wr(12'h100, 32'hffff_ffff, 4'hf);
      check({31'h0, se}, 32'h1, "unmapped write error");
      apb_rd(12'h100);
      check({31'h0, se}, 32'h1, "unmapped read error");
      check(rd, 32'h0000_0000, "unmapped read data");
      apb_rd(iem_pkg::OFS_ENABLE);
      check(rd, ~pos_mask(10) & iem_pkg::IMPL_MASK, "enable untouched");
      $display("test unmapped done");
      // reset in mid-run: everything drops at once and comes back cleared
      apb_wr(iem_pkg::OFS_ENABLE, iem_pkg::IMPL_MASK, 4'hf);
      pulse(9);
      check({31'h0, irq}, 32'h1, "irq before reset");
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      #1;
      check({31'h0, irq}, 32'h0, "irq in reset");
      check({31'h0, timeout_fault_enable}, 32'h0, "timeout view in reset");
      @(posedge pclk);
      presetn <= 1'b1;
      apb_rd(iem_pkg::OFS_FLAG);
      check(rd, iem_pkg::RST_FLAG, "flags after mid reset");
      apb_rd(iem_pkg::OFS_ENABLE);
      check(rd, iem_pkg::RST_ENABLE, "enable after mid reset");
      $display("test reset done");
      complete_run();
   end

   // watchdog, well beyond the few hundred cycles the tests need
   initial begin
      repeat (20000) @(posedge pclk);
      err_count++;
      complete_run();
   end
endmodule
